// file: core/fbhs_status_map.sv
`timescale 1ns/1ps
`include "fbhs_defs.svh"
// Function
// - One health bit is kept for every fieldbus station.
// - A slave's health bit sits at base plus its station address.
// - The master's bit uses the same placement; master address 0 to 125.
// - Bit mapping: health length rounds up to a multiple of 16, 16 to 128.
// - Word mapping: health length is 1 to 8 words.
// - Diagnostics area is pending-station word then firmware version word.
// - Pending word shows the address of the first slave with diagnostics.
// - Mailbox retrieval clears that entry and the next pending address loads.
// - Pending word is zero whenever nothing is outstanding.
// - Version word: major revision high byte, minor revision low byte.
// - Diagnostics length 0/16/32 bits or 0/1/2 words; one word drops version.
// - Sync/freeze area is 0 or 16 bits, or 0 or 1 word.
// - On slave loss, inputs are held or cleared as configured.
// - With fault reporting on, loss and recovery each log one event.
// - Each change of the trigger bit sends the command to the group.
module fbhs_status_map (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Configuration
  input fbhs_pkg::fbhs_cfg_s cfg,
  input wire logic [127:0] stn_cfg_mask,
  // Fieldbus engine side
  input fbhs_pkg::fbhs_stn_evt_s stn_evt,
  input wire logic master_run,
  input wire logic diag_set_valid,
  input wire logic [6:0] diag_set_addr,
  input wire logic read_pending_diag_request,
  // Host produced area
  input wire logic [15:0] sf_ctrl_word,
  // Host consumed image
  output logic [127:0] station_health_bits,
  output logic [15:0] pending_diag_station,
  output logic [15:0] firmware_version_word,
  // Actions towards the fieldbus and the fault log
  output fbhs_pkg::fbhs_sf_cmd_s sf_cmd,
  output fbhs_pkg::fbhs_fault_s fault_evt,
  output fbhs_pkg::fbhs_stn_evt_s input_clear
);

  // ****************************************
  // Area lengths
  // ****************************************
  logic [8:0] hl_round;
  logic [4:0] hw_raw;
  logic [4:0] hwords;
  logic [1:0] diag_words;
  logic sf_on;

  assign hl_round = {1'b0, cfg.health_len} + `FBHS_HL_ROUND;
  assign hw_raw = (cfg.mode == fbhs_pkg::map_bit) ? hl_round[8:4] : {1'b0, cfg.health_len[3:0]};
  assign hwords = (hw_raw < `FBHS_HW_MIN) ? `FBHS_HW_MIN :
                  (hw_raw > `FBHS_HW_MAX) ? `FBHS_HW_MAX : hw_raw;
  assign diag_words = (cfg.mode == fbhs_pkg::map_bit) ?
                      ((cfg.diag_len == `FBHS_DIAG_BITS2) ? 2'h2 : (cfg.diag_len == `FBHS_DIAG_BITS1) ? 2'h1 : 2'h0) :
                      ((cfg.diag_len >= `FBHS_DIAG_WORDS2) ? 2'h2 : cfg.diag_len[1:0]);
  assign sf_on = (cfg.mode == fbhs_pkg::map_bit) ? (cfg.sf_len == `FBHS_SF_BITS) : (cfg.sf_len != 5'h00);

  // ****************************************
  // Health array and pending flags
  // ****************************************
  logic [127:0] health_reg;
  logic [127:0] health_next;
  logic [127:0] len_mask;
  logic [127:0] pend_reg;
  logic [127:0] pend_next;
  logic [6:0] pend_first;
  logic pend_any;

  genvar gi;
  generate
    for (gi = 0; gi < `FBHS_NST; gi++) begin : g_stn
      logic hit;
      logic is_master;
      assign hit = stn_evt.valid && (stn_evt.addr == 7'(gi));
      assign is_master = (cfg.master_addr == 7'(gi)) && (cfg.master_addr <= `FBHS_MAX_ADDR);
      // Master bit follows its own run state; slaves follow exchange events
      assign health_next[gi] = is_master ? master_run :
                               !stn_cfg_mask[gi] ? 1'b0 :
                               hit ? stn_evt.ok : health_reg[gi];
      // New diagnostics win over a retrieval in the same cycle
      assign pend_next[gi] = (diag_set_valid && (diag_set_addr == 7'(gi))) ||
                             (pend_reg[gi] && !(read_pending_diag_request && pend_first == 7'(gi)));
      assign len_mask[gi] = (5'(gi / 16) < hwords);
    end
  endgenerate

  // Lowest pending address counts as the first one
  always_comb begin
    pend_first = 7'h00;
    pend_any = 1'b0;
    for (int i = `FBHS_NST - 1; i >= 0; i--) begin
      if (pend_reg[i]) begin
        pend_first = 7'(i);
        pend_any = 1'b1;
      end
    end
  end

  // Next shown address, taken from the flags as they will stand
  logic [6:0] show_next;
  always_comb begin
    show_next = 7'h00;
    for (int i = `FBHS_NST - 1; i >= 0; i--) begin
      if (pend_next[i]) begin
        show_next = 7'(i);
      end
    end
  end

  // ****************************************
  // Loss, recovery and sync/freeze events
  // ****************************************
  logic evt_cfg;
  logic evt_change;
  logic trig_prev_reg;
  logic primed_reg;
  logic trig_flip;

  assign evt_cfg = stn_evt.valid && stn_cfg_mask[stn_evt.addr] && (stn_evt.addr != cfg.master_addr);
  assign evt_change = evt_cfg && (health_reg[stn_evt.addr] != stn_evt.ok);
  // Slaves keep sync/freeze state themselves; the block only forwards codes
  assign trig_flip = primed_reg && (sf_ctrl_word[`FBHS_SF_TRIG_BIT] != trig_prev_reg);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      health_reg <= 128'h0;
      pend_reg <= 128'h0;
      station_health_bits <= 128'h0;
      pending_diag_station <= 16'h0000;
      firmware_version_word <= 16'h0000;
    end else begin
      health_reg <= health_next;
      pend_reg <= pend_next;
      station_health_bits <= health_next & len_mask;
      pending_diag_station <= (diag_words != 2'h0) ? {9'h000, show_next} : 16'h0000;
      firmware_version_word <= (diag_words == 2'h2) ? {`FBHS_FW_MAJOR, `FBHS_FW_MINOR} : 16'h0000;
    end
  end

  // Trigger is sampled once after reset before edges count, so a word that
  // already has bit 15 set does not fire a command at power up
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trig_prev_reg <= 1'b0;
      primed_reg <= 1'b0;
      sf_cmd <= '0;
    end else begin
      trig_prev_reg <= sf_ctrl_word[`FBHS_SF_TRIG_BIT];
      primed_reg <= 1'b1;
      sf_cmd.valid <= trig_flip && sf_on;
      sf_cmd.group <= sf_ctrl_word[7:0];
      sf_cmd.cmd <= sf_ctrl_word[15:8];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_evt <= '0;
      input_clear <= '0;
    end else begin
      fault_evt.valid <= evt_change && cfg.fault_en;
      fault_evt.addr <= stn_evt.addr;
      fault_evt.lost <= !stn_evt.ok;
      input_clear.valid <= evt_change && !stn_evt.ok && cfg.clear_on_loss;
      input_clear.addr <= stn_evt.addr;
      input_clear.ok <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_health_up;
    evt_cfg && stn_evt.ok |=> health_reg[$past(stn_evt.addr)];
  endproperty
  a_health_up: assert property (p_health_up) else $error("health bit not set on good exchange");

  property p_health_down;
    evt_cfg && !stn_evt.ok |=> !health_reg[$past(stn_evt.addr)];
  endproperty
  a_health_down: assert property (p_health_down) else $error("health bit not cleared on loss");

  // The first edge after reset still sees the reset image, so it is skipped
  property p_master_bit;
    $stable(cfg.master_addr) && $past(rstn) && cfg.master_addr <= `FBHS_MAX_ADDR
      |-> health_reg[cfg.master_addr] == $past(master_run);
  endproperty
  a_master_bit: assert property (p_master_bit) else $error("master health bit wrong");

  property p_len_mask;
    hwords < `FBHS_HW_MAX |=> station_health_bits[127:112] == 16'h0000;
  endproperty
  a_len_mask: assert property (p_len_mask) else $error("health bits beyond length visible");

  property p_diag_zero;
    pend_reg == 128'h0 |-> pending_diag_station == 16'h0000;
  endproperty
  a_diag_zero: assert property (p_diag_zero) else $error("pending word nonzero with nothing pending");

  property p_diag_first;
    pend_any && diag_words != 2'h0 && !$past(read_pending_diag_request) && !$past(diag_set_valid)
      |-> pending_diag_station == {9'h000, pend_first};
  endproperty
  a_diag_first: assert property (p_diag_first) else $error("pending word not first station");

  property p_diag_set_wins;
    diag_set_valid |=> pend_reg[$past(diag_set_addr)];
  endproperty
  a_diag_set_wins: assert property (p_diag_set_wins) else $error("new diagnostics lost");

  property p_fw_word;
    diag_words == 2'h2 |=> firmware_version_word == {`FBHS_FW_MAJOR, `FBHS_FW_MINOR};
  endproperty
  a_fw_word: assert property (p_fw_word) else $error("version word wrong");

  property p_sf_send;
    trig_flip && sf_on |=> sf_cmd.valid && sf_cmd.cmd == $past(sf_ctrl_word[15:8])
      && sf_cmd.group == $past(sf_ctrl_word[7:0]);
  endproperty
  a_sf_send: assert property (p_sf_send) else $error("command not sent on trigger change");

  property p_sf_quiet;
    $stable(sf_ctrl_word[15]) && primed_reg ##1 $stable(sf_ctrl_word[15]) |=> !sf_cmd.valid;
  endproperty
  a_sf_quiet: assert property (p_sf_quiet) else $error("command sent without trigger change");

  property p_fault_log;
    evt_change |=> fault_evt.valid == $past(cfg.fault_en) && fault_evt.lost == !$past(stn_evt.ok);
  endproperty
  a_fault_log: assert property (p_fault_log) else $error("fault event wrong");

  property p_clear_policy;
    input_clear.valid |-> $past(cfg.clear_on_loss) && fault_evt.lost;
  endproperty
  a_clear_policy: assert property (p_clear_policy) else $error("inputs cleared against policy");

  property p_health_unconf;
    stn_evt.valid && !stn_cfg_mask[stn_evt.addr] && stn_evt.addr != cfg.master_addr
      |=> !health_reg[$past(stn_evt.addr)];
  endproperty
  a_health_unconf: assert property (p_health_unconf) else $error("unconfigured station shows healthy");

  property p_fault_quiet;
    !cfg.fault_en |=> !fault_evt.valid;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("fault event logged while reporting is off");

  property p_clear_send;
    evt_change && !stn_evt.ok && cfg.clear_on_loss
      |=> input_clear.valid && input_clear.addr == $past(stn_evt.addr) && !input_clear.ok;
  endproperty
  a_clear_send: assert property (p_clear_send) else $error("lost station inputs not cleared");

  property p_hold_inputs;
    !cfg.clear_on_loss |=> !input_clear.valid;
  endproperty
  a_hold_inputs: assert property (p_hold_inputs) else $error("inputs cleared while hold is chosen");

  property p_hwords_range;
    hwords >= `FBHS_HW_MIN && hwords <= `FBHS_HW_MAX;
  endproperty
  a_hwords_range: assert property (p_hwords_range) else $error("health length outside 1 to 8 words");

  // Checked against the rule, not against the rounding adder above
  property p_bit_round;
    cfg.mode == fbhs_pkg::map_bit && cfg.health_len != 8'h00 && cfg.health_len <= 8'h80
      |-> {hwords, 4'h0} >= {1'b0, cfg.health_len} && {hwords, 4'h0} < {1'b0, cfg.health_len} + 9'h010;
  endproperty
  a_bit_round: assert property (p_bit_round) else $error("bit length not rounded up to 16");

  property p_word_len;
    cfg.mode == fbhs_pkg::map_word && cfg.health_len[3:0] != 4'h0 && cfg.health_len[3:0] <= 4'h8
      |-> hwords == {1'b0, cfg.health_len[3:0]};
  endproperty
  a_word_len: assert property (p_word_len) else $error("word length not taken as given");

  property p_sf_off;
    !sf_on |=> !sf_cmd.valid;
  endproperty
  a_sf_off: assert property (p_sf_off) else $error("command sent with control area off");

  property p_diag_off;
    diag_words == 2'h0 |=> pending_diag_station == 16'h0000 && firmware_version_word == 16'h0000;
  endproperty
  a_diag_off: assert property (p_diag_off) else $error("diagnostics area shown with zero length");

  // ****************************************
  // Covers
  // ****************************************
  c_loss: cover property (evt_change && !stn_evt.ok ##1 fault_evt.valid);
  c_diag_next: cover property (read_pending_diag_request && pend_reg != 128'h0 ##1 pend_any);
  c_sf_cmd: cover property (sf_cmd.valid && sf_cmd.cmd[7]);
  c_short_diag: cover property (diag_words == 2'h1 && pending_diag_station != 16'h0000);

endmodule // fbhs_status_map

// file: core/fbhs_defs.svh
`ifndef FBHS_DEFS_SVH
`define FBHS_DEFS_SVH
// Station image geometry
`define FBHS_NST 128
`define FBHS_NWORD 8
`define FBHS_MAX_ADDR 7'h7d
// Health length limits in 16-bit words, and the bit rounding addend
`define FBHS_HW_MIN 5'h01
`define FBHS_HW_MAX 5'h08
`define FBHS_HL_ROUND 9'h00f
// Diagnostics area lengths
`define FBHS_DIAG_BITS1 6'h10
`define FBHS_DIAG_BITS2 6'h20
`define FBHS_DIAG_WORDS2 6'h02
// Sync/freeze area lengths
`define FBHS_SF_BITS 5'h10
// Control word layout and command codes
`define FBHS_SF_TRIG_BIT 15
`define FBHS_CMD_UNFREEZE 8'h04
`define FBHS_CMD_FREEZE 8'h08
`define FBHS_CMD_UNSYNC 8'h10
`define FBHS_CMD_SYNC 8'h20
`define FBHS_CMD_TRIGGER 8'h80
// Firmware revision, arbitrary values
`define FBHS_FW_MAJOR 8'h01
`define FBHS_FW_MINOR 8'h00
`endif

// file: core/fbhs_pkg.sv
package fbhs_pkg;
  typedef enum logic {map_bit, map_word} fbhs_map_e;
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic ok;
  } fbhs_stn_evt_s;
  typedef struct packed {
    logic valid;
    logic [7:0] group;
    logic [7:0] cmd;
  } fbhs_sf_cmd_s;
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic lost;
  } fbhs_fault_s;
  typedef struct packed {
    fbhs_map_e mode;
    logic [6:0] master_addr;
    logic [7:0] health_len;
    logic [5:0] diag_len;
    logic [4:0] sf_len;
    logic clear_on_loss;
    logic fault_en;
  } fbhs_cfg_s;
endpackage

// file: tb/fbhs_host_model.sv
`timescale 1ns/1ps
module fbhs_host_model (
  // Clock
  input wire logic ref_clk,
  // Host produced area and mailbox strobe
  output logic [15:0] sf_ctrl_word,
  output logic read_pending_diag_request
);
  initial begin
    sf_ctrl_word = 16'h0000;
    read_pending_diag_request = 1'b0;
  end
  // Word is settled one cycle before the trigger flips, so the command never fires half written
  task automatic send_sf(input logic [7:0] grp, input logic [6:0] code);
    @(negedge ref_clk);
    sf_ctrl_word = {sf_ctrl_word[15], code, grp};
    @(negedge ref_clk);
    sf_ctrl_word[15] = ~sf_ctrl_word[15];
  endtask
  task automatic read_diag();
    @(negedge ref_clk);
    read_pending_diag_request = 1'b1;
    @(negedge ref_clk);
    read_pending_diag_request = 1'b0;
  endtask
endmodule // fbhs_host_model

// file: tb/fbhs_status_map_tb.sv
`timescale 1ns/1ps
`include "fbhs_defs.svh"
module fbhs_status_map_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  fbhs_pkg::fbhs_cfg_s cfg;
  logic [127:0] stn_cfg_mask;
  fbhs_pkg::fbhs_stn_evt_s stn_evt;
  logic master_run;
  logic diag_set_valid;
  logic [6:0] diag_set_addr;
  logic read_pending_diag_request;
  logic [15:0] sf_ctrl_word;
  logic [127:0] station_health_bits;
  logic [15:0] pending_diag_station;
  logic [15:0] firmware_version_word;
  fbhs_pkg::fbhs_sf_cmd_s sf_cmd;
  fbhs_pkg::fbhs_fault_s fault_evt;
  fbhs_pkg::fbhs_stn_evt_s input_clear;
  int err_total = 0;
  int checked = 0;
  int hl = 128;
  int diag_q[$];
  bit [127:0] slave_ok = '0;
  logic [7:0] codes [4] = '{`FBHS_CMD_UNFREEZE, `FBHS_CMD_FREEZE, `FBHS_CMD_UNSYNC, `FBHS_CMD_SYNC};
  always #10 ref_clk = ~ref_clk;
  fbhs_status_map fbhs_status_map_inst (.ref_clk(ref_clk), .rstn(rstn), .cfg(cfg), .stn_cfg_mask(stn_cfg_mask),
    .stn_evt(stn_evt), .master_run(master_run), .diag_set_valid(diag_set_valid), .diag_set_addr(diag_set_addr),
    .read_pending_diag_request(read_pending_diag_request), .sf_ctrl_word(sf_ctrl_word),
    .station_health_bits(station_health_bits), .pending_diag_station(pending_diag_station),
    .firmware_version_word(firmware_version_word), .sf_cmd(sf_cmd), .fault_evt(fault_evt), .input_clear(input_clear));
  fbhs_host_model fbhs_host_model_inst (.ref_clk(ref_clk), .sf_ctrl_word(sf_ctrl_word),
    .read_pending_diag_request(read_pending_diag_request));
  // ****************************************
  // Model and compare helpers
  // ****************************************
  function automatic logic [127:0] img();
    logic [127:0] v;
    v = slave_ok & stn_cfg_mask;
    v[cfg.master_addr] = master_run;
    return v & ~({128{1'b1}} << hl);
  endfunction
  function automatic logic [15:0] pend();
    return (diag_q.size() > 0) ? 16'(diag_q[0]) : 16'h0000;
  endfunction
  task automatic chk_img(input string what, input logic [127:0] exp, input logic [127:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Fields of an idle pulse are left unchecked, since the design may keep stale values there
  task automatic chk_evt(input string what, input logic ev, input logic [15:0] ef, input logic gv, input logic [15:0] gf);
    checked++;
    if (gv !== ev || (ev && gf !== ef)) begin
      err_total++;
      $display("CHECK FAILED %s expected %b/%h seen %b/%h", what, ev, ef, gv, gf);
    end
  endtask
  task automatic ev(input int a, input logic ok);
    logic chg;
    chg = stn_cfg_mask[a] && slave_ok[a] != ok;
    stn_evt = '{1'b1, 7'(a), ok};
    @(negedge ref_clk);
    stn_evt.valid = 1'b0;
    if (chg) begin
      slave_ok[a] = ok;
    end
    chk_evt("fault", chg && cfg.fault_en, {8'h0, 7'(a), ~ok}, fault_evt.valid,
      {8'h0, fault_evt.addr, fault_evt.lost});
    chk_evt("clear", chg && cfg.clear_on_loss && !ok, {8'h0, 7'(a), 1'b0}, input_clear.valid,
      {8'h0, input_clear.addr, input_clear.ok});
    chk_img("health", img(), station_health_bits);
    // Idle cycle, so a following call never raises valid in the step that lowered it
    @(negedge ref_clk);
  endtask
  task automatic dset(input int a);
    diag_set_valid = 1'b1;
    diag_set_addr = 7'(a);
    @(negedge ref_clk);
    diag_set_valid = 1'b0;
    diag_q.push_back(a);
    diag_q.sort();
    @(negedge ref_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    #200000;
    err_total++;
    summarize();
  end
  initial begin
    int a;
    int b;
    logic [7:0] g;
    cfg = '{fbhs_pkg::map_bit, 7'h08, 8'h80, 6'h20, 5'h10, 1'b0, 1'b1};
    stn_cfg_mask = '1;
    stn_evt = '0;
    master_run = 1'b1;
    diag_set_valid = 1'b0;
    diag_set_addr = 7'h00;
    void'($urandom(32'hb9de));
    cfg.master_addr = 7'($urandom_range(125, 8));
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    chk_img("fw", 128'({`FBHS_FW_MAJOR, `FBHS_FW_MINOR}), 128'(firmware_version_word));
    chk_img("health", img(), station_health_bits);
    // Every combination of clear and fault policy, plus a refused unconfigured station
    stn_cfg_mask[7] = 1'b0;
    for (int p = 0; p < 4; p++) begin
      cfg.clear_on_loss = p[0];
      cfg.fault_en = p[1];
      master_run = p[1];
      a = $urandom_range(cfg.master_addr - 1);
      ev(5, 1'b1);
      ev(5, 1'b1);
      ev(a, 1'b1);
      ev(5, 1'b0);
      ev(7, 1'b1);
    end
    // Length clamping in both mappings, and rounding in bit mapping
    for (int k = 0; k < 4; k++) begin
      cfg.mode = (k == 1 || k == 2) ? fbhs_pkg::map_word : fbhs_pkg::map_bit;
      cfg.health_len = (k == 0) ? 8'h14 : (k == 1) ? 8'h02 : (k == 2) ? 8'h09 : 8'h00;
      hl = (k == 2) ? 128 : (k == 3) ? 16 : 32;
      @(negedge ref_clk);
      chk_img("health_len", img(), station_health_bits);
    end
    a = $urandom_range(60, 1);
    b = a + 1 + $urandom_range(60);
    dset(b);
    dset(a);
    chk_img("pending", 128'(pend()), 128'(pending_diag_station));
    for (int k = 0; k < 2; k++) begin
      fbhs_host_model_inst.read_diag();
      void'(diag_q.pop_front());
      chk_img("pending", 128'(pend()), 128'(pending_diag_station));
    end
    dset(b);
    cfg.diag_len = `FBHS_DIAG_BITS1;
    @(negedge ref_clk);
    chk_img("fw_short", 128'h0, 128'(firmware_version_word));
    chk_img("pending", 128'(pend()), 128'(pending_diag_station));
    cfg.diag_len = 6'h00;
    @(negedge ref_clk);
    chk_img("pending_off", 128'h0, 128'(pending_diag_station));
    // Each command once, one of them in word mapping, then with the control area switched off
    for (int k = 0; k < 5; k++) begin
      cfg.mode = (k == 3) ? fbhs_pkg::map_word : fbhs_pkg::map_bit;
      cfg.sf_len = (k == 4) ? 5'h00 : (k == 3) ? 5'h01 : `FBHS_SF_BITS;
      g = 8'($urandom_range(255));
      fbhs_host_model_inst.send_sf(g, codes[k % 4][6:0]);
      @(negedge ref_clk);
      chk_evt("sf", k < 4, {g, sf_ctrl_word[15], codes[k % 4][6:0]}, sf_cmd.valid,
        {sf_cmd.group, sf_cmd.cmd});
      @(negedge ref_clk);
      chk_evt("sf_idle", 1'b0, 16'h0, sf_cmd.valid, 16'h0);
    end
    summarize();
  end
endmodule // fbhs_status_map_tb
